/* core/pwm_edge_timing_aux_sr.sv */
// Edge timing for the second rectifier falling edge and the auxiliary output.
// Assumes AHB-Lite slave access, one 125 MHz clock, same-clock loop modulation.
`timescale 1ns/1ps
`default_nettype none
module pwm_edge_timing_aux_sr
  import pwm_timing_pkg::*;
#(
  parameter int TIME_W = 12
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [TIME_W-1:0] loop_modulation,
  input wire logic main_blank_sync,
  output logic rectifier_drive_two,
  output logic auxiliary_pwm_drive,
  output logic regulation_source_select,
  output logic cs_blank_sync,
  output logic period_start
);
  // Bus state
  logic wr_pend_d;
  logic wr_pend_q;
  logic [7:0] wr_idx_d;
  logic [7:0] wr_idx_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic accept;
  logic addr_ok;
  logic [7:0] a_idx;
  logic [7:0] wbyte;

  // Staged registers, written by software
  logic [7:0] s_r2ft_d, s_r2ft_q;
  logic [7:0] s_r2fs_d, s_r2fs_q;
  logic [7:0] s_art_d, s_art_q;
  logic [7:0] s_ars_d, s_ars_q;
  logic [7:0] s_aft_d, s_aft_q;
  logic [7:0] s_afs_d, s_afs_q;
  logic [7:0] s_dis_d, s_dis_q;
  logic [7:0] s_plo_d, s_plo_q;
  logic [7:0] s_phi_d, s_phi_q;
  logic go_d;
  logic go_q;

  // Active copies used by the timing logic
  logic [7:0] a_r2ft_d, a_r2ft_q;
  logic [7:0] a_r2fs_d, a_r2fs_q;
  logic [7:0] a_art_d, a_art_q;
  logic [7:0] a_ars_d, a_ars_q;
  logic [7:0] a_aft_d, a_aft_q;
  logic [7:0] a_afs_d, a_afs_q;
  logic [7:0] a_dis_d, a_dis_q;
  logic [11:0] a_per_d, a_per_q;

  // Timing state
  logic [15:0] phase_d, phase_q;
  logic [15:0] period_ns;
  logic wrap;
  logic r2_d, r2_q;
  logic aux_d, aux_q;
  logic blank_d, blank_q;
  logic start_d, start_q;
  logic [TIME_W+3:0] r2_fall_ns;
  logic [TIME_W+3:0] aux_rise_ns;
  logic [TIME_W+3:0] aux_fall_ns;
  logic reg_sel;

  assign a_idx = haddr[9:2];
  assign addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
  assign accept = hsel && htrans[1] && hready;
  assign wbyte = hwdata[7:0];

  // Bus address and read data capture
  always_comb begin
    logic [7:0] v;
    v = 8'h00;
    wr_pend_d = accept && hwrite && addr_ok;
    wr_idx_d = a_idx;
    rdata_d = rdata_q;
    if (accept && !hwrite) begin
      unique case (a_idx)
        IDX_RECT2_FALL_TIMING: v = s_r2ft_d;
        IDX_RECT2_FALL_SETTING: v = s_r2fs_d;
        IDX_AUX_RISE_TIMING: v = s_art_d;
        IDX_AUX_RISE_SETTING: v = s_ars_d;
        IDX_AUX_FALL_TIMING: v = s_aft_d;
        IDX_AUX_FALL_SETTING: v = s_afs_d;
        IDX_OUTPUT_DISABLE: v = s_dis_d;
        IDX_PERIOD_LOW: v = s_plo_d;
        IDX_PERIOD_HIGH: v = s_phi_d;
        IDX_STATUS: v = {4'h0, blank_q, a_afs_q[BIT_REG_SELECT], aux_q, r2_q};
        default: v = 8'h00;
      endcase
      rdata_d = addr_ok ? {24'h0, v} : 32'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
      rdata_q <= 32'h0;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_idx_q <= wr_idx_d;
      rdata_q <= rdata_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // Staged register writes in the data phase
  always_comb begin
    s_r2ft_d = s_r2ft_q;
    s_r2fs_d = s_r2fs_q;
    s_art_d = s_art_q;
    s_ars_d = s_ars_q;
    s_aft_d = s_aft_q;
    s_afs_d = s_afs_q;
    s_dis_d = s_dis_q;
    s_plo_d = s_plo_q;
    s_phi_d = s_phi_q;
    go_d = 1'b0;
    if (wr_pend_q) begin
      unique case (wr_idx_q)
        IDX_RECT2_FALL_TIMING: s_r2ft_d = wbyte;
        IDX_RECT2_FALL_SETTING: s_r2fs_d = wbyte;
        IDX_AUX_RISE_TIMING: s_art_d = wbyte;
        IDX_AUX_RISE_SETTING: s_ars_d = wbyte;
        IDX_AUX_FALL_TIMING: s_aft_d = wbyte;
        IDX_AUX_FALL_SETTING: s_afs_d = wbyte;
        IDX_OUTPUT_DISABLE: begin
          s_dis_d = {wbyte[7:1], 1'b0};
          go_d = wbyte[BIT_LATCH];
        end
        IDX_PERIOD_LOW: s_plo_d = wbyte;
        IDX_PERIOD_HIGH: s_phi_d = {4'h0, wbyte[3:0]};
        default: go_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_r2ft_q <= REG_RESET;
      s_r2fs_q <= REG_RESET;
      s_art_q <= REG_RESET;
      s_ars_q <= REG_RESET;
      s_aft_q <= REG_RESET;
      s_afs_q <= REG_RESET;
      s_dis_q <= REG_RESET;
      s_plo_q <= PERIOD_RESET[7:0];
      s_phi_q <= {4'h0, PERIOD_RESET[11:8]};
      go_q <= 1'b0;
    end else begin
      s_r2ft_q <= s_r2ft_d;
      s_r2fs_q <= s_r2fs_d;
      s_art_q <= s_art_d;
      s_ars_q <= s_ars_d;
      s_aft_q <= s_aft_d;
      s_afs_q <= s_afs_d;
      s_dis_q <= s_dis_d;
      s_plo_q <= s_plo_d;
      s_phi_q <= s_phi_d;
      go_q <= go_d;
    end
  end

  // Latch strobe copies staged values into the active set
  always_comb begin
    a_r2ft_d = a_r2ft_q;
    a_r2fs_d = a_r2fs_q;
    a_art_d = a_art_q;
    a_ars_d = a_ars_q;
    a_aft_d = a_aft_q;
    a_afs_d = a_afs_q;
    a_dis_d = a_dis_q;
    a_per_d = a_per_q;
    if (go_q) begin
      a_r2ft_d = s_r2ft_q;
      a_r2fs_d = s_r2fs_q;
      a_art_d = s_art_q;
      a_ars_d = s_ars_q;
      a_aft_d = s_aft_q;
      a_afs_d = s_afs_q;
      a_dis_d = s_dis_q;
      a_per_d = {s_phi_q[3:0], s_plo_q};
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      a_r2ft_q <= REG_RESET;
      a_r2fs_q <= REG_RESET;
      a_art_q <= REG_RESET;
      a_ars_q <= REG_RESET;
      a_aft_q <= REG_RESET;
      a_afs_q <= REG_RESET;
      a_dis_q <= REG_RESET;
      a_per_q <= PERIOD_RESET;
    end else begin
      a_r2ft_q <= a_r2ft_d;
      a_r2fs_q <= a_r2fs_d;
      a_art_q <= a_art_d;
      a_ars_q <= a_ars_d;
      a_aft_q <= a_aft_d;
      a_afs_q <= a_afs_d;
      a_dis_q <= a_dis_d;
      a_per_q <= a_per_d;
    end
  end

  assign reg_sel = a_afs_q[BIT_REG_SELECT];
  assign regulation_source_select = reg_sel;

  // Rectifier two falling edge, modulated only in normal mode
  pwm_edge_unit #(.TIME_W(TIME_W)) u_rect2_fall (
    .clock(clock),
    .srst(srst),
    .base_time({a_r2ft_q, a_r2fs_q[TIME_NIBBLE_HI:TIME_NIBBLE_LO]}),
    .mod_enable(a_r2fs_q[BIT_MOD_ENABLE]),
    .mod_later(a_r2fs_q[BIT_MOD_LATER]),
    .mod_allowed(!reg_sel),
    .modulation(loop_modulation),
    .edge_ns(r2_fall_ns)
  );

  // Auxiliary rising edge, modulated only when it regulates
  pwm_edge_unit #(.TIME_W(TIME_W)) u_aux_rise (
    .clock(clock),
    .srst(srst),
    .base_time({a_art_q, a_ars_q[TIME_NIBBLE_HI:TIME_NIBBLE_LO]}),
    .mod_enable(a_ars_q[BIT_MOD_ENABLE]),
    .mod_later(a_ars_q[BIT_MOD_LATER]),
    .mod_allowed(reg_sel),
    .modulation(loop_modulation),
    .edge_ns(aux_rise_ns)
  );

  // Auxiliary falling edge
  pwm_edge_unit #(.TIME_W(TIME_W)) u_aux_fall (
    .clock(clock),
    .srst(srst),
    .base_time({a_aft_q, a_afs_q[TIME_NIBBLE_HI:TIME_NIBBLE_LO]}),
    .mod_enable(a_afs_q[BIT_MOD_ENABLE]),
    .mod_later(a_afs_q[BIT_MOD_LATER]),
    .mod_allowed(reg_sel),
    .modulation(loop_modulation),
    .edge_ns(aux_fall_ns)
  );

  // Period phase in ns, advanced by one clock period per edge
  assign period_ns = 16'(a_per_q) * 16'(STEP_MULT);
  assign wrap = (phase_q + PHASE_STEP) >= period_ns;

  always_comb begin
    phase_d = wrap ? 16'h0 : phase_q + PHASE_STEP;
    start_d = wrap;
    r2_d = (16'(r2_fall_ns) > phase_d) && !a_dis_q[BIT_RECT2_DISABLE];
    aux_d = (phase_d >= 16'(aux_rise_ns)) && (phase_d < 16'(aux_fall_ns))
      && !a_dis_q[BIT_AUX_DISABLE];
    blank_d = reg_sel ? (aux_d && !aux_q) : main_blank_sync;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      phase_q <= 16'h0;
      start_q <= 1'b0;
      r2_q <= 1'b0;
      aux_q <= 1'b0;
      blank_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      start_q <= start_d;
      r2_q <= r2_d;
      aux_q <= aux_d;
      blank_q <= blank_d;
    end
  end

  assign rectifier_drive_two = r2_q;
  assign auxiliary_pwm_drive = aux_q;
  assign cs_blank_sync = blank_q;
  assign period_start = start_q;
endmodule : pwm_edge_timing_aux_sr
`default_nettype wire

/* core/pwm_edge_unit.sv */
// One programmable edge: base time plus or minus loop modulation, in ns.
// Assumes modulation comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module pwm_edge_unit
  import pwm_timing_pkg::*;
#(
  parameter int TIME_W = 12
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [TIME_W-1:0] base_time,
  input wire logic mod_enable,
  input wire logic mod_later,
  input wire logic mod_allowed,
  input wire logic [TIME_W-1:0] modulation,
  output logic [TIME_W+3:0] edge_ns
);
  logic [TIME_W:0] sum;
  logic [TIME_W-1:0] eff;
  logic [TIME_W+3:0] edge_ns_d;
  logic [TIME_W+3:0] edge_ns_q;

  always_comb begin
    sum = '0;
    eff = base_time;
    if (mod_enable && mod_allowed) begin
      if (mod_later) begin
        sum = {1'b0, base_time} + {1'b0, modulation};
        eff = sum[TIME_W] ? {TIME_W{1'b1}} : sum[TIME_W-1:0];
      end else begin
        sum = {1'b0, base_time} - {1'b0, modulation};
        eff = sum[TIME_W] ? '0 : sum[TIME_W-1:0];
      end
    end
    edge_ns_d = (TIME_W+4)'(eff) * (TIME_W+4)'(STEP_MULT);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      edge_ns_q <= '0;
    end else begin
      edge_ns_q <= edge_ns_d;
    end
  end

  assign edge_ns = edge_ns_q;
endmodule : pwm_edge_unit
`default_nettype wire

/* core/pwm_timing_pkg.sv */
// Shared constants for the auxiliary and second-rectifier edge timing block.
// Assumes a single 125 MHz clock and AHB-Lite register access.
package pwm_timing_pkg;
  // Register indexes, byte address is four times the index
  localparam logic [7:0] IDX_RECT2_FALL_TIMING = 8'h57;
  localparam logic [7:0] IDX_RECT2_FALL_SETTING = 8'h58;
  localparam logic [7:0] IDX_AUX_RISE_TIMING = 8'h59;
  localparam logic [7:0] IDX_AUX_RISE_SETTING = 8'h5a;
  localparam logic [7:0] IDX_AUX_FALL_TIMING = 8'h5b;
  localparam logic [7:0] IDX_AUX_FALL_SETTING = 8'h5c;
  localparam logic [7:0] IDX_OUTPUT_DISABLE = 8'h5d;
  localparam logic [7:0] IDX_PERIOD_LOW = 8'h70;
  localparam logic [7:0] IDX_PERIOD_HIGH = 8'h71;
  localparam logic [7:0] IDX_STATUS = 8'h72;
  // Field positions
  localparam int TIME_NIBBLE_HI = 7;
  localparam int TIME_NIBBLE_LO = 4;
  localparam int BIT_MOD_ENABLE = 3;
  localparam int BIT_MOD_LATER = 2;
  localparam int BIT_REG_SELECT = 1;
  localparam int BIT_AUX_DISABLE = 7;
  localparam int BIT_RECT2_DISABLE = 6;
  localparam int BIT_LATCH = 0;
  // Values after reset
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [11:0] PERIOD_RESET = 12'h7d0;
  // Timing
  localparam int STEP_NS = 5;
  localparam int CLOCK_NS = 8;
  localparam logic [15:0] PHASE_STEP = 16'(CLOCK_NS);
  localparam logic [2:0] STEP_MULT = 3'(STEP_NS);
endpackage : pwm_timing_pkg

/* tb/gate_stage_model.sv */
// Gate stage: counts drive-high cycles and blank pulses per period.
// Assumes period_start marks each switching period.
`timescale 1ns/1ps
`default_nettype none
module gate_stage_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic rect_drive,
  input wire logic aux_drive,
  input wire logic blank,
  input wire logic period_start,
  output logic main_blank_sync,
  output logic done,
  output logic [31:0] result
);
  logic [11:0] cyc, rc, ac;
  logic [7:0] bc;
  // Two main-output blank pulses per period
  always @(posedge clock) begin
    main_blank_sync <= cyc == 12'h00a || cyc == 12'h258;
    done <= period_start && !srst;
    if (srst || period_start) begin
      result <= {rc, ac, bc};
      cyc <= 12'h0;
      rc <= {11'h0, rect_drive};
      ac <= {11'h0, aux_drive};
      bc <= {7'h0, blank};
    end else begin
      cyc <= cyc + 12'h1;
      rc <= rc + {11'h0, rect_drive};
      ac <= ac + {11'h0, aux_drive};
      bc <= bc + {7'h0, blank};
    end
  end
endmodule : gate_stage_model
`default_nettype wire

/* tb/pwm_edge_props_properties.sv */
// Checker for the aux and rectifier-two edge timing block.
// Assumes the block's top ports and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module pwm_edge_props (
  input wire logic clock,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic main_blank_sync,
  input wire logic rectifier_drive_two,
  input wire logic auxiliary_pwm_drive,
  input wire logic regulation_source_select,
  input wire logic cs_blank_sync,
  input wire logic period_start
);
  logic [11:0] gap_q, gap_d;
  logic seen_q, seen_d, adr_q, adr_d;
  logic [3:0] go_q, go_d;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  always_comb begin
    adr_d = hsel && htrans[1] && hready && hwrite && haddr == 32'h174;
    gap_d = period_start ? 12'h1 : gap_q + 12'h1;
    seen_d = seen_q || period_start;
    go_d = adr_q && hwdata[0] ? 4'h0 : go_q + 4'(go_q != 4'hf);
  end
  always_ff @(posedge clock) begin
    adr_q <= adr_d;
    gap_q <= srst ? 12'h0 : gap_d;
    seen_q <= !srst && seen_d;
    go_q <= srst ? 4'hf : go_d;
  end
  sequence s_once(x);
    x ##1 !x;
  endsequence
  sequence s_go;
    adr_d ##1 hwdata[0];
  endsequence
  property p_start;
    period_start |-> s_once(period_start);
  endproperty
  a_start: assert property (p_start) else $error("period start too long");
  property p_gap;
    period_start && seen_q |-> gap_q == 12'h4e2;
  endproperty
  a_gap: assert property (p_gap) else $error("period length wrong");
  property p_norm;
    !regulation_source_select && !$past(regulation_source_select) && !$past(srst)
      |-> cs_blank_sync == $past(main_blank_sync);
  endproperty
  a_norm: assert property (p_norm) else $error("blank not from main");
  property p_pulse;
    regulation_source_select && cs_blank_sync |-> s_once(cs_blank_sync);
  endproperty
  a_pulse: assert property (p_pulse) else $error("aux blank too long");
  property p_rise;
    regulation_source_select && $past(regulation_source_select, 3) && $rose(auxiliary_pwm_drive)
      |-> $past(cs_blank_sync) or ##[0:2] cs_blank_sync;
  endproperty
  a_rise: assert property (p_rise) else $error("no blank at aux rise");
  property p_aux_off;
    s_go ##0 hwdata[7] |-> ##[1:6] !auxiliary_pwm_drive [*8];
  endproperty
  a_aux_off: assert property (p_aux_off) else $error("aux not off");
  property p_rect_off;
    s_go ##0 hwdata[6] |-> ##[1:6] !rectifier_drive_two [*8];
  endproperty
  a_rect_off: assert property (p_rect_off) else $error("rect not off");
  property p_sel;
    $changed(regulation_source_select) |-> go_q <= 4'h6;
  endproperty
  a_sel: assert property (p_sel) else $error("select moved unlatched");
endmodule : pwm_edge_props
bind pwm_edge_timing_aux_sr pwm_edge_props u_props (.clock, .srst, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .main_blank_sync, .rectifier_drive_two, .auxiliary_pwm_drive, .regulation_source_select,
  .cs_blank_sync, .period_start);
`default_nettype wire

/* tb/tb_top.sv */
// Bench for the aux and rectifier-two edge timing block.
// Assumes the gate-stage model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, w) begin num_checks++; if ((g) !== (w)) begin fail_count++; \
  $display("unexpected at %0t: %h vs %h", $time, g, w); end end
module tb_top;
  logic clock = 1'b0, srst = 1'b1, hwrite = 1'b0, rd_dp = 1'b0, in_meas = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, result, prev, want;
  logic [1:0] htrans = 2'h0;
  logic [11:0] loop_modulation = 12'h0;
  logic hreadyout, hresp, rectifier_drive_two, auxiliary_pwm_drive, regulation_source_select;
  logic cs_blank_sync, period_start, main_blank_sync, done;
  logic [31:0] expq[$];
  int fail_count = 0, num_checks = 0;
  always #4 clock = ~clock;
  pwm_edge_timing_aux_sr u_dut (.clock, .srst, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .loop_modulation, .main_blank_sync, .rectifier_drive_two,
    .auxiliary_pwm_drive, .regulation_source_select, .cs_blank_sync, .period_start);
  gate_stage_model u_stage (.clock, .srst, .rect_drive(rectifier_drive_two), .aux_drive(auxiliary_pwm_drive),
    .blank(cs_blank_sync), .period_start, .main_blank_sync, .done, .result);
  always @(posedge clock) begin
    if (rd_dp || (in_meas && done)) begin
      want = expq.pop_front();
      if (rd_dp) `CHK({hresp, hrdata}, {1'b0, want})
      else `CHK(result, want)
    end
  end
  task automatic xfer(input logic [7:0] i, input logic w, input logic [7:0] d);
    haddr <= {22'h0, i, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    rd_dp <= !w;
    do @(posedge clock); while (!hreadyout);
    rd_dp <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    expq.push_back({24'h0, e});
    xfer(i, 1'b0, 8'h0);
  endtask : rd
  task automatic measure(input logic [31:0] e);
    repeat (4) @(posedge clock);
    do @(posedge clock); while (!done);
    expq.push_back(e);
    in_meas <= 1'b1;
    do @(posedge clock); while (!done);
    in_meas <= 1'b0;
  endtask : measure
  function automatic int c8(input int ns);
    return (ns + 7) / 8;
  endfunction : c8
  function automatic int eff(input int b, input logic [1:0] md, input logic ok, input int m);
    if (!(md[1] && ok)) return b;
    b = md[0] ? b + m : b - m;
    return b < 0 ? 0 : b;
  endfunction : eff
  task automatic run(input int r, ar, af, input logic [1:0] mr, ma, mf, input logic sel, input int m,
                     input logic [1:0] dis);
    int aw;
    xfer(8'h57, 1'b1, r[11:4]);
    xfer(8'h58, 1'b1, {r[3:0], mr, 2'h0});
    xfer(8'h59, 1'b1, ar[11:4]);
    xfer(8'h5a, 1'b1, {ar[3:0], ma, 2'h0});
    xfer(8'h5b, 1'b1, af[11:4]);
    xfer(8'h5c, 1'b1, {af[3:0], mf, sel, 1'h0});
    measure(prev);
    loop_modulation <= 12'(m);
    xfer(8'h5d, 1'b1, {dis, 6'h01});
    aw = c8(eff(af, mf, sel, m) * 5) - c8(eff(ar, ma, sel, m) * 5);
    prev = {12'(dis[0] ? 0 : c8(eff(r, mr, !sel, m) * 5)), 12'(dis[1] ? 0 : aw), 8'(sel ? 1 : 2)};
    measure(prev);
    $display("edge test done, select %0d", sel);
  endtask : run
  task automatic test_done;
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  initial begin
    #480000;
    fail_count++;
    test_done();
  end
  initial begin
    logic [7:0] d;
    void'($urandom(32'hdd8a59c1));
    prev = 32'h2;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    for (int i = 8'h57; i < 8'h5e; i++) rd(8'(i), 8'h0);
    rd(8'h70, 8'hd0);
    rd(8'h71, 8'h07);
    for (int i = 8'h57; i < 8'h5d; i++) begin
      d = 8'($urandom) & (i[0] ? 8'hff : i == 8'h5c ? 8'hfe : 8'hfc);
      xfer(8'(i), 1'b1, d);
      rd(8'(i), d);
    end
    xfer(8'h5d, 1'b1, 8'hc0);
    rd(8'h5d, 8'hc0);
    xfer(8'h80, 1'b1, 8'h5a);
    rd(8'h80, 8'h0);
    $display("register test done");
    run(200, 300, 900, 2'h0, 2'h0, 2'h0, 1'b0, 0, 2'h0);
    run(200, 300, 900, 2'h3, 2'h3, 2'h3, 1'b0, 40, 2'h0);
    run(200, 300, 900, 2'h3, 2'h2, 2'h3, 1'b1, 40, 2'h0);
    run(200, 300, 900, 2'h0, 2'h0, 2'h0, 1'b1, 40, 2'h0);
    run(20, 300, 900, 2'h2, 2'h0, 2'h0, 1'b0, 100, 2'h0);
    run(200, 300, 900, 2'h0, 2'h0, 2'h0, 1'b0, 0, 2'h3);
    rd(8'h72, 8'h00);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
